/* design/shortest_path_indexer_command.sv */
// Command and handshake logic for the shortest-rotation indexer mode.
// Assumes all inputs are synchronous to mclk; the motion profile is outside
// and reports done and its in-window status through plain ports.
`timescale 1ns/100ps
`include "indexer_regs.svh"
module shortest_path_indexer_command
  import indexer_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire cmd_bits_t   cmd,
  input  wire params_t     prm,
  input  wire logic [15:0] next_station_word,
  input  wire logic [15:0] table_or_speed_word,
  input  wire logic        home_done,
  input  wire logic        pos_in_window,
  input  wire logic        motion_done,
  output move_req_t        move_req,
  output logic             move_launch,
  output logic             move_complete_bit,
  output logic             in_position_bit,
  output logic             home_incomplete_alarm,
  output logic             station_range_warning,
  output logic             alt_torque_limit_sel
);
  seq_state_t  state_reg;     // Sequencer state.
  seq_state_t  state_next;    // Next sequencer state.
  logic        start_d_reg;   // Start bit one cycle ago.
  logic        start_d_next;  // Next delayed start.
  move_req_t   req_reg;       // Latched move request.
  move_req_t   req_next;      // Next move request.
  logic        launch_reg;    // One-cycle launch pulse.
  logic        launch_next;   // Next launch pulse.
  logic        done_reg;      // Movement complete status.
  logic        done_next;     // Next movement complete.
  logic        inpos_reg;     // In-position status.
  logic        inpos_next;    // Next in-position.
  logic        alarm_reg;     // Home-incomplete alarm.
  logic        alarm_next;    // Next alarm.
  logic        warn_reg;      // Station range warning.
  logic        warn_next;     // Next warning.
  logic        mode_ok;       // Indexer auto mode 2 selected.
  logic        start_edge;    // Rising edge of start.
  logic [7:0]  target;        // Station chosen by the master now.
  logic        out_of_range;  // Target beyond the last station.

  // Tells whether a station lies beyond count minus one; a zero count makes
  // every station out of range rather than wrapping round.
  function automatic logic station_bad(input logic [7:0] st,
                                       input logic [7:0] count);
    station_bad = ({1'b0, st} + 9'h001) > {1'b0, count};
  endfunction : station_bad

  // Mode decode: top parameter digit and both mode bits from the master.
  assign mode_ok = (prm.operation_select_param == `OPSEL_INDEXER_DIGIT)
                   && cmd.op_mode_sel_a && cmd.op_mode_sel_b;

  // Rising edge of start is the only launch event.
  assign start_edge = cmd.start_cmd_bit && !start_d_reg;

  // Station source: register word in register mode, else select bits.
  // The direction parameter is deliberately not consulted here.
  always_comb
  begin
    if (cmd.register_drive_select)
    begin
      target = next_station_word[7:0];
    end
    else
    begin
      target = cmd.station_sel;
    end
  end

  assign out_of_range = station_bad(target, prm.station_count_param);

  // Sequencer: launches moves and drives the status bits.
  always_comb
  begin
    state_next   = state_reg;
    start_d_next = cmd.start_cmd_bit;
    req_next     = req_reg;
    launch_next  = 1'b0;
    done_next    = done_reg;
    inpos_next   = inpos_reg;
    alarm_next   = alarm_reg;
    warn_next    = out_of_range && mode_ok;
    case (state_reg)
      ST_IDLE:
      begin
        // Position check tracks the window whenever no move is under way.
        inpos_next = pos_in_window;
        if (start_edge && mode_ok)
        begin
          if (!home_done)
          begin
            alarm_next = 1'b1;
          end
          else if (!out_of_range)
          begin
            alarm_next         = 1'b0;
            req_next.station   = target;
            req_next.speed     = table_or_speed_word;
            req_next.direct_speed = 1'b0;
            req_next.table_idx = `TABLE_ENTRY_ONE;
            if (!cmd.register_drive_select)
            begin
              // Speed bits only count at the start edge.
              if (prm.two_stations)
              begin
                req_next.table_idx = cmd.speed_sel;
              end
            end
            else if (prm.speed_source_param == `SPEED_SRC_DIRECT
                     && prm.two_stations)
            begin
              req_next.direct_speed = 1'b1;
              req_next.table_idx    = `TABLE_ENTRY_ONE;
            end
            else
            begin
              // Table numbers count from one; zero falls back to entry one,
              // and entries past seven are clamped as a safety limit.
              if (table_or_speed_word == 16'h0000)
              begin
                req_next.table_idx = `TABLE_ENTRY_ONE;
              end
              else if (table_or_speed_word > 16'h0007)
              begin
                req_next.table_idx = `TABLE_MAX_REG_IDX;
              end
              else
              begin
                req_next.table_idx = table_or_speed_word[2:0] - 3'h1;
              end
            end
            launch_next = 1'b1;
            done_next   = 1'b0;
            inpos_next  = 1'b0;
            state_next  = ST_MOVE;
          end
        end
      end
      ST_MOVE:
      begin
        // Start edges here are simply dropped.
        if (motion_done)
        begin
          done_next  = 1'b1;
          inpos_next = pos_in_window;
          state_next = ST_IDLE;
        end
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Register the sequencer; complete reads high once reset is released.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg   <= ST_IDLE;
      start_d_reg <= 1'b0;
      req_reg     <= '0;
      launch_reg  <= 1'b0;
      done_reg    <= 1'b1;
      inpos_reg   <= 1'b0;
      alarm_reg   <= 1'b0;
      warn_reg    <= 1'b0;
    end
    else
    begin
      state_reg   <= state_next;
      start_d_reg <= start_d_next;
      req_reg     <= req_next;
      launch_reg  <= launch_next;
      done_reg    <= done_next;
      inpos_reg   <= inpos_next;
      alarm_reg   <= alarm_next;
      warn_reg    <= warn_next;
    end
  end

  // Torque limit switch-over timer.
  torque_delay i_torque_delay (
    .mclk    (mclk),
    .nrst    (nrst),
    .in_pos  (inpos_reg),
    .delay   (prm.torque_limit_delay_param),
    .use_alt (alt_torque_limit_sel)
  );

  assign move_req              = req_reg;
  assign move_launch           = launch_reg;
  assign move_complete_bit     = done_reg;
  assign in_position_bit       = inpos_reg;
  assign home_incomplete_alarm = alarm_reg;
  assign station_range_warning = warn_reg;
endmodule : shortest_path_indexer_command

/* design/indexer_regs.svh */
// Constants for the shortest-path indexer command block.
// Assumes inclusion from the package and design files by bare name.
`ifndef INDEXER_REGS_SVH
`define INDEXER_REGS_SVH
// Operation-select parameter: top digit 1 selects indexer positioning.
`define OPSEL_INDEXER_DIGIT 4'h1
// Speed-source digit values.
`define SPEED_SRC_TABLE     4'h0
`define SPEED_SRC_DIRECT    4'h1
// Point table entry used for direct speed ramps (table index 0 = No.1).
`define TABLE_ENTRY_ONE     3'h0
// Highest legal table index in register mode (No.7).
`define TABLE_MAX_REG_IDX   3'h6
// Reset values.
`define STATION_RESET       8'h00
`define DELAY_RESET         16'h0000
`endif

/* design/indexer_pkg.sv */
// Types shared by the indexer command block and its delay timer.
// Assumes the constants header sits beside it.
package indexer_pkg;
  `include "indexer_regs.svh"

  // Master command bits gathered from the remote inputs.
  typedef struct packed {
    logic       start_cmd_bit;          // Start request.
    logic       op_mode_sel_a;          // Mode select, first bit.
    logic       op_mode_sel_b;          // Mode select, second bit.
    logic       register_drive_select;  // Register-driven selection.
    logic [7:0] station_sel;            // Station select bits, bit0 first.
    logic [2:0] speed_sel;              // Speed select bits, bit0 first.
  } cmd_bits_t;

  // Parameter settings.
  typedef struct packed {
    logic [3:0]  operation_select_param; // Top digit of operation select.
    logic [3:0]  speed_source_param;     // Speed-source digit.
    logic [7:0]  station_count_param;    // Number of stations.
    logic        station_dir_param;      // Unused in this mode.
    logic [15:0] torque_limit_delay_param; // Delay in clock cycles.
    logic        two_stations;           // Device occupies two stations.
  } params_t;

  // Move request handed to the motion profile.
  typedef struct packed {
    logic [7:0]  station;       // Target station.
    logic        direct_speed;  // Speed taken from the word.
    logic [15:0] speed;         // Direct speed value.
    logic [2:0]  table_idx;     // Table entry for speed or ramps.
  } move_req_t;

  // Command sequencer states.
  typedef enum logic [1:0] {ST_IDLE, ST_MOVE} seq_state_t;
endpackage : indexer_pkg

/* design/torque_delay.sv */
// Delay timer that switches to the alternate torque limit after in-position.
// Assumes in_pos is synchronous to mclk and delay is held steady.
`timescale 1ns/100ps
`include "indexer_regs.svh"
module torque_delay
  import indexer_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        in_pos,
  input  wire logic [15:0] delay,
  output logic             use_alt
);
  logic [15:0] cnt_reg;   // Cycles spent in position.
  logic [15:0] cnt_next;  // Next count.
  logic        alt_reg;   // Alternate limit selected.
  logic        alt_next;  // Next selection.

  // Count while in position; leaving position drops the alternate limit.
  always_comb
  begin
    cnt_next = cnt_reg;
    alt_next = alt_reg;
    if (!in_pos)
    begin
      cnt_next = `DELAY_RESET;
      alt_next = 1'b0;
    end
    else if (cnt_reg >= delay)
    begin
      alt_next = 1'b1;
    end
    else
    begin
      cnt_next = cnt_reg + 16'h0001;
    end
  end

  // Register the timer state.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_reg <= `DELAY_RESET;
      alt_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      alt_reg <= alt_next;
    end
  end

  assign use_alt = alt_reg;
endmodule : torque_delay

/* verif/motion_profile_model.sv */
// Stand-in for the motion profile that sits beyond the command block.
// Assumes a launch is a one-cycle pulse synchronous to mclk.
`timescale 1ns/100ps
module motion_profile_model
(
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       move_launch,
  input  wire logic [7:0] lat,
  output logic            motion_done,
  output logic            pos_in_window
);
  logic [7:0] cnt_reg;  // Cycles left in the running move.
  logic [7:0] cnt_next; // Next count.

  // A move lasts lat cycles; the shaft leaves the window while it runs.
  always_comb
  begin
    cnt_next = cnt_reg;
    if (move_launch)
      cnt_next = lat;
    else if (cnt_reg != 8'h00)
      cnt_next = cnt_reg - 8'h01;
  end

  // Done pulses on the last cycle, so a slow lat stretches the busy time.
  // The shaft already sits in the window on that last cycle, so the
  // in-position sample taken with done is a true one.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      cnt_reg <= 8'h00;
    else
      cnt_reg <= cnt_next;
  end
  assign motion_done   = (cnt_reg == 8'h01);
  assign pos_in_window = (cnt_reg <= 8'h01);
endmodule : motion_profile_model

/* verif/shortest_path_indexer_command_asserts.sv */
// Checker for the indexer command block, bound to its top module.
// Assumes the bench holds the torque delay at four cycles.
`timescale 1ns/100ps
module spi_checker
  import indexer_pkg::*;
(
  input wire logic        mclk,
  input wire logic        nrst,
  input wire cmd_bits_t   cmd,
  input wire params_t     prm,
  input wire logic [15:0] next_station_word,
  input wire logic        home_done,
  input wire logic        pos_in_window,
  input wire logic        motion_done,
  input wire move_req_t   move_req,
  input wire logic        move_launch,
  input wire logic        move_complete_bit,
  input wire logic        in_position_bit,
  input wire logic        home_incomplete_alarm,
  input wire logic        station_range_warning,
  input wire logic        alt_torque_limit_sel
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  logic mode_ok; // Indexer digit and both mode bits present.
  assign mode_ok = prm.operation_select_param == 4'h1 &&
                   cmd.op_mode_sel_a && cmd.op_mode_sel_b;

  property p_busy;
    move_launch |-> $past(move_complete_bit) && !move_complete_bit;
  endproperty
  a_busy: assert property (p_busy) else $error("launch while busy");
  property p_pulse;
    move_launch |=> !move_launch;
  endproperty
  a_pulse: assert property (p_pulse) else $error("long launch");
  property p_mode;
    move_launch |-> $past(mode_ok && cmd.start_cmd_bit && home_done);
  endproperty
  a_mode: assert property (p_mode) else $error("bad launch");
  property p_alarm;
    $rose(home_incomplete_alarm) |-> $past(!home_done) && !move_launch;
  endproperty
  a_alarm: assert property (p_alarm) else $error("bad alarm");
  property p_hold;
    !move_launch |-> $stable(move_req);
  endproperty
  a_hold: assert property (p_hold) else $error("request moved");
  property p_warn;
    $past(nrst && mode_ok && cmd.register_drive_select) |->
      station_range_warning ==
      $past(next_station_word[7:0] >= prm.station_count_param);
  endproperty
  a_warn: assert property (p_warn) else $error("bad warning");
  property p_done;
    motion_done && !move_complete_bit |=> move_complete_bit;
  endproperty
  a_done: assert property (p_done) else $error("no complete");
  property p_inpos;
    $rose(move_complete_bit) |-> in_position_bit == $past(pos_in_window);
  endproperty
  a_inpos: assert property (p_inpos) else $error("bad in-position");
  property p_alt;
    $rose(in_position_bit) && prm.torque_limit_delay_param == 16'h0004 |->
      !alt_torque_limit_sel [*5] ##1 alt_torque_limit_sel;
  endproperty
  a_alt: assert property (p_alt) else $error("bad torque switch");
  c_launch: cover property (move_launch);
  c_alarm: cover property ($rose(home_incomplete_alarm));
  c_warn: cover property (station_range_warning);
endmodule : spi_checker
bind shortest_path_indexer_command spi_checker i_spi_checker
(
  .mclk, .nrst, .cmd, .prm, .next_station_word, .home_done,
  .pos_in_window, .motion_done, .move_req, .move_launch,
  .move_complete_bit, .in_position_bit, .home_incomplete_alarm,
  .station_range_warning, .alt_torque_limit_sel
);

/* verif/shortest_path_indexer_command_tb.sv */
// Self-checking bench for the indexer command block.
// Assumes the package, the design and the profile stand-in are compiled.
`timescale 1ns/100ps
module shortest_path_indexer_command_tb
  import indexer_pkg::*;
;
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  cmd_bits_t   cmd;
  params_t     prm;
  logic [15:0] nsw;
  logic [15:0] tsw;
  logic        home_done;
  logic [7:0]  lat;
  logic        motion_done, pos_in_window, move_launch, move_complete_bit;
  logic        in_position_bit, home_incomplete_alarm;
  logic        station_range_warning, alt_torque_limit_sel;
  move_req_t   move_req;
  int          n_fail = 0;
  int          total_checks = 0;
  int          n_launch = 0;
  int          cycles = 0;

  always #5 mclk = ~mclk;
  // Launch counter and hang guard share one clocked process.
  always @(posedge mclk)
  begin
    cycles++;
    if (move_launch === 1'b1)
      n_launch++;
    if (cycles == 5000)
    begin
      n_fail++;
      final_report();
    end
  end

  shortest_path_indexer_command i_shortest_path_indexer_command
  (
    .mclk, .nrst, .cmd, .prm, .next_station_word(nsw),
    .table_or_speed_word(tsw), .home_done, .pos_in_window, .motion_done,
    .move_req, .move_launch, .move_complete_bit, .in_position_bit,
    .home_incomplete_alarm, .station_range_warning, .alt_torque_limit_sel
  );
  motion_profile_model i_motion_profile_model
  (
    .mclk, .nrst, .move_launch, .lat, .motion_done, .pos_in_window
  );

  task final_report;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Raise start for a few cycles; selections were set well before.
  task go;
    @(posedge mclk);
    cmd.start_cmd_bit <= 1'b1;
    repeat (3) @(posedge mclk);
    cmd.start_cmd_bit <= 1'b0;
    @(posedge mclk);
  endtask : go

  // Wait for completion, then leave room for the torque switch.
  task wait_idle;
    for (int i = 0; i < 300 && move_complete_bit !== 1'b1; i++)
      @(posedge mclk);
    repeat (8) @(posedge mclk);
    chk(move_complete_bit, 1);
  endtask : wait_idle

  // Bit selection: speed bits are frozen and restarts ignored mid-move.
  task t_bits;
    int n0;
    n0 = n_launch;
    go();
    chk(n_launch, n0 + 1);
    chk(move_req.station, 3);
    chk(move_req.table_idx, 5);
    chk(home_incomplete_alarm, 0);
    chk(move_complete_bit, 0);
    cmd.speed_sel <= 3'h2;
    go();
    chk(n_launch, n0 + 1);
    chk(move_req.table_idx, 5);
    wait_idle();
    chk(in_position_bit, 1);
    chk(alt_torque_limit_sel, 1);
  endtask : t_bits

  // Register selection in table mode, then direct speed.
  task t_reg(input logic [3:0] src, input logic two, input logic [2:0] idx,
             input logic dir);
    prm.speed_source_param <= src;
    prm.two_stations <= two;
    prm.station_dir_param <= ~prm.station_dir_param;
    repeat (2) @(posedge mclk);
    go();
    chk(move_req.station, 2);
    chk(move_req.direct_speed, dir);
    chk(move_req.table_idx, idx);
    if (dir)
      chk(move_req.speed, 16'h1234);
    wait_idle();
  endtask : t_reg

  initial
  begin
    cmd = '0;
    cmd.op_mode_sel_a = 1'b1;
    cmd.op_mode_sel_b = 1'b1;
    cmd.station_sel = 8'h03;
    cmd.speed_sel = 3'h5;
    prm = '0;
    prm.operation_select_param = 4'h1;
    prm.station_count_param = 8'h04;
    prm.torque_limit_delay_param = 16'h0004;
    prm.two_stations = 1'b1;
    nsw = 16'h0002;
    tsw = 16'h0003;
    home_done = 1'b0;
    lat = 8'h28;
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    repeat (4) @(posedge mclk);
    chk(in_position_bit, 1);
    go();
    chk(home_incomplete_alarm, 1);
    chk(n_launch, 0);
    home_done <= 1'b1;
    t_bits();
    lat <= 8'h02;
    prm.two_stations <= 1'b0;
    go();
    chk(move_req.table_idx, 0);
    wait_idle();
    cmd.register_drive_select <= 1'b1;
    t_reg(4'h0, 1'b1, 3'h2, 1'b0);
    tsw <= 16'h1234;
    t_reg(4'h1, 1'b1, 3'h0, 1'b1);
    // Table numbers stay within one to seven while table mode is in use.
    tsw <= 16'h0007;
    t_reg(4'h1, 1'b0, 3'h6, 1'b0);
    nsw <= 16'h0004;
    go();
    chk(station_range_warning, 1);
    chk(n_launch, 5);
    wait_idle();
    nsw <= 16'h0003;
    repeat (2) @(posedge mclk);
    chk(station_range_warning, 0);
    prm.operation_select_param <= 4'h0;
    go();
    chk(move_complete_bit, 1);
    chk(n_launch, 5);
    final_report();
  end
endmodule : shortest_path_indexer_command_tb
